// ---- scs_pkg.sv ----
// constants and types for the startup and cycle time setup block
package scs_pkg;
  // ***************************
  // register indexes (byte addr = 4 * index)
  // ***************************
  localparam logic [13:0] IDX_MODE = 14'h19C8;
  localparam logic [13:0] IDX_HOLD = 14'h19C9;
  localparam logic [13:0] IDX_PROT = 14'h19CA;
  localparam logic [13:0] IDX_BKUP = 14'h19CC;
  localparam logic [13:0] IDX_PERI = 14'h19D9;
  localparam logic [13:0] IDX_MON = 14'h19DA;
  localparam logic [13:0] IDX_MIN = 14'h19DB;
  localparam logic [13:0] IDX_ELOG = 14'h19FF;
  localparam logic [13:0] IDX_STS = 14'h1A00;
  localparam logic [13:0] IDX_MASK = 14'h1A01;
  localparam logic [13:0] IDX_CTRL = 14'h1A02;
  localparam logic [13:0] IDX_STATE = 14'h1A03;
  // ***************************
  // field positions and codes
  // ***************************
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_SET = 3;
  localparam int CTRL_IOH = 4;
  localparam int CTRL_FRC = 5;
  localparam int CTRL_HOLD_SET = 6;
  localparam int STS_OVER = 0;
  localparam int STS_LONG = 1;
  localparam int STS_PREJ = 2;
  localparam int STS_RST = 3;
  localparam int NSTS = 4;
  localparam logic [7:0] DSG_SWITCH = 8'h00;
  localparam logic [7:0] DSG_LAST = 8'h01;
  localparam logic [7:0] DSG_WORD = 8'h02;
  localparam logic [7:0] EN_00 = 8'h00;
  localparam logic [7:0] EN_01 = 8'h01;
  localparam logic [7:0] EN_02 = 8'h02;
  localparam logic [7:0] EN_03 = 8'h03;
  localparam logic [3:0] NIB_0 = 4'h0;
  localparam logic [3:0] NIB_1 = 4'h1;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // ***************************
  // timing
  // ***************************
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam logic [16:0] FIXED_LIMIT_MS = 17'd120;
  localparam logic [16:0] MAX_LIMIT_MS = 17'd99000;
  localparam logic [16:0] UNIT_10MS = 17'd10;
  localparam logic [16:0] UNIT_100MS = 17'd100;
  localparam logic [16:0] UNIT_1S = 17'd1000;
  localparam logic [6:0] FIXED_PCT = 7'd5;
  localparam logic [6:0] FULL_PCT = 7'd100;
  typedef enum logic [1:0] {MODE_PROG, MODE_MON, MODE_RUN, MODE_BAD} scs_mode_t;
  typedef enum logic [1:0] {SC_IDLE, SC_EXEC, SC_SERV, SC_PAD} scs_scan_t;
  // two bcd digits to binary
  function automatic logic [6:0] scs_bcd2(input logic [7:0] b);
    scs_bcd2 = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction : scs_bcd2
  // four bcd digits to binary
  function automatic logic [13:0] scs_bcd4(input logic [15:0] b);
    scs_bcd4 = 14'(b[15:12]) * 14'd1000 + 14'(b[11:8]) * 14'd100
             + 14'(b[7:4]) * 14'd10 + 14'(b[3:0]);
  endfunction : scs_bcd4
endpackage : scs_pkg

// ---- scs_setup.sv ----
// startup and cycle time setup block with apb register access
// What this block does
// - with designation 02 the start mode is the low byte of the mode word (00/01/02).
// - the designation byte picks the switch, the last mode, or the stored low byte.
// - startup words act only when a restart happens, not when written.
// - at restart the io memory hold flag clears on nibble 0 and stays on nibble 1.
// - at restart the forced state hold flag clears on nibble 0 and stays on nibble 1.
// - protect nibble 1 rejects program memory writes, its own word still writable.
// - the language nibble picks english (0) or japanese (1) for the console.
// - cycle words act only at the next start of operation.
// - service enable 01 gives the port the bcd percentage of each scan.
// - service enable 00 gives the port a fixed 5 percent and ignores the byte.
// - the overrun limit is the bcd byte times the unit, at most 99 s.
// - monitor enable 00 gives 120 ms, 01/02/03 pick 10 ms, 100 ms, 1 s units.
// - minimum scan word 0000 is no minimum, else scans last at least that many ms.
// - long cycle nibble 0 reports an overrun as a non-fatal error, 1 does not.
//
// Chosen here: the APB register port.
module scs_setup
  import scs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [1:0] mode_switch, // console switch pins
  input wire logic restart_req, // restart pulse
  input wire logic exec_done, // program pass finished
  input wire logic pm_wr_req, // program memory write request
  output logic pm_wr_ok, // write accepted pulse
  output logic pm_wr_rej, // write rejected pulse
  output logic [1:0] op_mode, // operating mode
  output logic io_hold, // io memory hold flag
  output logic force_hold, // forced state hold flag
  output logic lang_jp, // console language japanese
  output logic scan_start, // scan start pulse
  output logic periph_grant, // port service window
  output logic cycle_err, // non-fatal long cycle pulse
  output logic irq // interrupt level
);
  typedef struct packed {
    logic [7:0][15:0] cfg;
    logic [1:0] sw_a;
    logic [1:0] sw_b;
    logic boot;
    scs_mode_t mode;
    scs_mode_t last_mode;
    logic io_h;
    logic frc_h;
    logic prot;
    logic lang;
    logic [6:0] pct;
    logic [16:0] lim_ms;
    logic [13:0] min_ms;
    logic detect;
    scs_scan_t scan;
    logic [16:0] div;
    logic [16:0] el_ms;
    logic over_seen;
    logic [23:0] credit;
    logic [NSTS-1:0] sts;
    logic [NSTS-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pm_ok;
    logic pm_rej;
    logic scan_st;
    logic serv;
    logic cerr;
    logic irq;
  } scs_st_t;

  scs_st_t s;
  scs_st_t next_s;

  // ***************************
  // combinational next state
  // ***************************
  logic [13:0] idx;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd;
  logic do_restart;
  logic op_start;
  scs_mode_t new_mode;
  logic mode_chg;
  logic [NSTS-1:0] ev;
  logic [NSTS-1:0] clr;
  logic [16:0] lim;
  logic [6:0] cost;
  logic tick;

  always_comb begin
    next_s = s;
    idx = paddr[15:2];
    // arm once per transfer so pready stays a single pulse
    acc = psel & penable & ~s.pready;
    // a write lands on the edge where the master sees pready
    wr = psel & penable & s.pready & pwrite & (paddr[1:0] == 2'b00);
    ev = '0;
    clr = '0;
    lim = FIXED_LIMIT_MS;
    cost = FULL_PCT - s.pct;
    new_mode = s.mode;
    mode_chg = 1'b0;
    do_restart = s.boot | restart_req;
    op_start = 1'b0;
    tick = 1'b0;
    // switch pins, two stages before use
    next_s.sw_a = mode_switch;
    next_s.sw_b = s.sw_a;
    next_s.boot = 1'b0;
    next_s.pm_ok = 1'b0;
    next_s.pm_rej = 1'b0;
    next_s.scan_st = 1'b0;
    next_s.cerr = 1'b0;
    // read mux and decode
    mapped = 1'b1;
    rd = '0;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx == IDX_MODE) begin
      rd = {16'h0000, s.cfg[0]};
    end else if (idx == IDX_HOLD) begin
      rd = {16'h0000, s.cfg[1]};
    end else if (idx == IDX_PROT) begin
      rd = {16'h0000, s.cfg[2]};
    end else if (idx == IDX_BKUP) begin
      rd = {16'h0000, s.cfg[3]};
    end else if (idx == IDX_PERI) begin
      rd = {16'h0000, s.cfg[4]};
    end else if (idx == IDX_MON) begin
      rd = {16'h0000, s.cfg[5]};
    end else if (idx == IDX_MIN) begin
      rd = {16'h0000, s.cfg[6]};
    end else if (idx == IDX_ELOG) begin
      rd = {16'h0000, s.cfg[7]};
    end else if (idx == IDX_STS) begin
      rd = 32'(s.sts);
    end else if (idx == IDX_MASK) begin
      rd = 32'(s.mask);
    end else if (idx == IDX_CTRL) begin
      rd = 32'({s.frc_h, s.io_h, 3'b000, 1'b0});
      rd[CTRL_MODE_LO +: 2] = s.mode;
    end else if (idx == IDX_STATE) begin
      rd = 32'({s.detect, s.lang, s.prot, s.frc_h, s.io_h, s.scan, s.mode});
    end else begin
      mapped = 1'b0;
    end
    // ***************************
    // apb slave, answer one cycle into access
    // ***************************
    next_s.pready = acc;
    if (acc) begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      next_s.pslverr = ~mapped;
    end else begin
      // read data stands for the answer cycle only
      next_s.prdata = '0;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
    // config words just store; they act at restart or op start
    if (wr) begin
      if (idx == IDX_MODE) begin
        next_s.cfg[0] = pwdata[15:0];
      end else if (idx == IDX_HOLD) begin
        next_s.cfg[1] = pwdata[15:0];
      end else if (idx == IDX_PROT) begin
        next_s.cfg[2] = pwdata[15:0];
      end else if (idx == IDX_BKUP) begin
        next_s.cfg[3] = pwdata[15:0];
      end else if (idx == IDX_PERI) begin
        next_s.cfg[4] = pwdata[15:0];
      end else if (idx == IDX_MON) begin
        next_s.cfg[5] = pwdata[15:0];
      end else if (idx == IDX_MIN) begin
        next_s.cfg[6] = pwdata[15:0];
      end else if (idx == IDX_ELOG) begin
        next_s.cfg[7] = pwdata[15:0];
      end else if (idx == IDX_STS) begin
        clr = pwdata[NSTS-1:0];
      end else if (idx == IDX_MASK) begin
        next_s.mask = pwdata[NSTS-1:0];
      end else if (idx == IDX_CTRL) begin
        do_restart = do_restart | pwdata[CTRL_RESTART];
        if (pwdata[CTRL_MODE_SET] && pwdata[CTRL_MODE_LO +: 2] != MODE_BAD) begin
          new_mode = scs_mode_t'(pwdata[CTRL_MODE_LO +: 2]);
          mode_chg = 1'b1;
        end
        if (pwdata[CTRL_HOLD_SET]) begin
          next_s.io_h = pwdata[CTRL_IOH];
          next_s.frc_h = pwdata[CTRL_FRC];
        end
      end
    end
    // ***************************
    // restart: startup words take effect
    // ***************************
    if (do_restart) begin
      ev[STS_RST] = 1'b1;
      mode_chg = 1'b1;
      if (s.cfg[0][15:8] == DSG_SWITCH) begin
        // switch code 3 has no mode, so program
        new_mode = (s.sw_b == MODE_BAD) ? MODE_PROG : scs_mode_t'(s.sw_b);
      end else if (s.cfg[0][15:8] == DSG_LAST) begin
        new_mode = s.last_mode;
      end else if (s.cfg[0][15:8] == DSG_WORD && s.cfg[0][7:0] <= 8'h02) begin
        new_mode = scs_mode_t'(s.cfg[0][1:0]);
      end else begin
        // unknown designation or mode code falls back to program
        new_mode = MODE_PROG;
      end
      if (s.cfg[1][11:8] == NIB_0) begin
        next_s.io_h = 1'b0;
      end
      if (s.cfg[1][15:12] == NIB_0) begin
        next_s.frc_h = 1'b0;
      end
      next_s.prot = (s.cfg[2][3:0] == NIB_1);
      next_s.lang = (s.cfg[2][7:4] == NIB_1);
    end
    // ***************************
    // mode change and start of operation
    // ***************************
    if (mode_chg) begin
      next_s.mode = new_mode;
      // remembered for designation 01, program mode included
      next_s.last_mode = new_mode;
      op_start = (new_mode != MODE_PROG) & ((s.mode == MODE_PROG) | do_restart);
      if (new_mode == MODE_PROG) begin
        next_s.scan = SC_IDLE;
        next_s.serv = 1'b0;
      end
    end
    // cycle words are sampled only here, at the start of operation
    if (op_start) begin
      if (s.cfg[4][15:8] == EN_01) begin
        next_s.pct = scs_bcd2(s.cfg[4][7:0]);
      end else begin
        next_s.pct = FIXED_PCT;
      end
      if (s.cfg[5][15:8] == EN_01) begin
        lim = 17'(scs_bcd2(s.cfg[5][7:0])) * UNIT_10MS;
      end else if (s.cfg[5][15:8] == EN_02) begin
        lim = 17'(scs_bcd2(s.cfg[5][7:0])) * UNIT_100MS;
      end else if (s.cfg[5][15:8] == EN_03) begin
        lim = 17'(scs_bcd2(s.cfg[5][7:0])) * UNIT_1S;
      end
      // clamp keeps the limit at 99 s at most
      next_s.lim_ms = (lim > MAX_LIMIT_MS) ? MAX_LIMIT_MS : lim;
      next_s.min_ms = scs_bcd4(s.cfg[6]);
      next_s.detect = (s.cfg[7][11:8] == NIB_0);
      next_s.scan = SC_IDLE;
      next_s.serv = 1'b0;
    end
    // ***************************
    // program memory write gate
    // ***************************
    // no address on this port, so the protect word is always written over apb
    if (pm_wr_req) begin
      next_s.pm_ok = ~s.prot;
      next_s.pm_rej = s.prot;
      ev[STS_PREJ] = s.prot;
    end
    // ***************************
    // scan pacing
    // ***************************
    // millisecond tick, restarted with every scan
    if (s.div == 17'(TICK_CYCLES - 1)) begin
      next_s.div = '0;
      tick = 1'b1;
    end else begin
      next_s.div = s.div + 17'd1;
    end
    if (tick && s.el_ms != 17'h1FFFF) begin
      next_s.el_ms = s.el_ms + 17'd1;
    end
    if (!mode_chg && !op_start) begin
      case (s.scan)
        SC_IDLE: begin
          if (s.mode != MODE_PROG) begin
            next_s.scan = SC_EXEC;
            next_s.scan_st = 1'b1;
            next_s.el_ms = '0;
            next_s.div = '0;
            next_s.over_seen = 1'b0;
            next_s.credit = '0;
          end
        end
        SC_EXEC: begin
          // credit saturates rather than wrapping on a very long pass
          if (!s.credit[23]) begin
            next_s.credit = s.credit + 24'(s.pct);
          end
          if (exec_done) begin
            next_s.scan = SC_SERV;
            next_s.serv = 1'b1;
          end
        end
        SC_SERV: begin
          // service time grows with exec time in ratio pct to 100-pct
          if (s.pct != 7'd0 && s.credit >= 24'(cost)) begin
            next_s.credit = s.credit - 24'(cost);
          end else begin
            next_s.scan = SC_PAD;
            next_s.serv = 1'b0;
          end
        end
        SC_PAD: begin
          // hold here until the minimum scan time has passed
          if (s.el_ms >= 17'(s.min_ms)) begin
            next_s.scan = SC_IDLE;
          end
        end
        default: begin
          next_s.scan = SC_IDLE;
        end
      endcase
    end
    // overrun check, once per scan
    if (s.scan != SC_IDLE && !s.over_seen && s.el_ms > s.lim_ms) begin
      next_s.over_seen = 1'b1;
      ev[STS_OVER] = 1'b1;
      ev[STS_LONG] = s.detect;
      next_s.cerr = s.detect;
    end
    // ***************************
    // interrupt status, set wins over clear
    // ***************************
    next_s.sts = (s.sts & ~clr) | ev;
    next_s.irq = |(next_s.sts & next_s.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // storage is not kept over reset, words clear
      s <= '0;
      s.boot <= 1'b1;
      s.pct <= FIXED_PCT;
      s.lim_ms <= FIXED_LIMIT_MS;
      s.cfg <= {8{CFG_RST}};
    end else begin
      s <= next_s;
    end
  end

  // ***************************
  // outputs
  // ***************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pm_wr_ok = s.pm_ok;
  assign pm_wr_rej = s.pm_rej;
  assign op_mode = s.mode;
  assign io_hold = s.io_h;
  assign force_hold = s.frc_h;
  assign lang_jp = s.lang;
  assign scan_start = s.scan_st;
  assign periph_grant = s.serv;
  assign cycle_err = s.cerr;
  assign irq = s.irq;
endmodule : scs_setup

// ---- scs_setup_bench.sv ----
// self-checking bench for the startup and cycle time setup block
module scs_setup_bench import scs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restart_req = 1'b0;
  logic exec_done = 1'b0, pm_wr_req = 1'b0, exec_on = 1'b0, pg_d = 1'b0, re;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [1:0] mode_switch = 2'h0, op_mode, pm;
  logic pready, pslverr, pm_wr_ok, pm_wr_rej, io_hold, force_hold, lang_jp;
  logic scan_start, periph_grant, cycle_err, irq;
  int err_count = 0, n_compared = 0, cyc = 0, cnt = 0, glen = 0, glast = 0, n_err = 0;
  int last_start = 0, prev_start = 0, err_cyc = 0, nb, lo, hi;
  logic [13:0] cfg [8] = '{IDX_MODE, IDX_HOLD, IDX_PROT, IDX_BKUP, IDX_PERI, IDX_MON,
    IDX_MIN, IDX_ELOG};
  logic [19:0] mt [10] = '{20'h50000, 20'hA0000, 20'h00002, 20'h40201, 20'h80202,
    20'h80100, 20'h00300, 20'h80202, 20'h00203, 20'h00100};
  logic [17:0] ht [4] = '{18'h00000, 18'h21000, 18'h10100, 18'h31100};
  logic [31:0] st [5] = '{32'h0150, 32'h0175, 32'h0075, 32'h00200150, 32'h0100};
  int gl [5] = '{40, 120, 2, 40, 1};
  int mp [5] = '{0, 0, 0, 200, 0};
  logic [31:0] ot [6] = '{32'h01010101, 32'h02010201, 32'h00050005, 32'h03010301,
    32'h01010000, 32'h01120112};
  int om [6] = '{10, 100, 120, 1000, 120, 120};
  always #4 clk = ~clk;
  scs_setup #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_switch(mode_switch), .restart_req(restart_req),
    .exec_done(exec_done), .pm_wr_req(pm_wr_req), .pm_wr_ok(pm_wr_ok),
    .pm_wr_rej(pm_wr_rej), .op_mode(op_mode), .io_hold(io_hold), .force_hold(force_hold),
    .lang_jp(lang_jp), .scan_start(scan_start), .periph_grant(periph_grant),
    .cycle_err(cycle_err), .irq(irq));
  // ***************************
  // scan recorder and timeout
  // ***************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cnt <= (scan_start === 1'b1) ? 0 : cnt + 1;
    exec_done <= exec_on && cnt == 38;
    if (scan_start === 1'b1) begin
      prev_start <= last_start;
      last_start <= cyc;
    end
    pg_d <= periph_grant;
    if (periph_grant === 1'b1) glen <= pg_d ? glen + 1 : 1;
    if (periph_grant === 1'b0 && pg_d) glast <= glen;
    if (cycle_err === 1'b1) begin
      err_cyc <= cyc;
      n_err <= n_err + 1;
    end
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
    chk("write error", 32'h0, {31'h0, re});
  endtask : wr
  task automatic rd(input logic [13:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk("read data", e, rv);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic boot();
    @(posedge clk);
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
    tick(2);
  endtask : boot
  task automatic pmw(input logic ok);
    @(posedge clk);
    pm_wr_req <= 1'b1;
    @(posedge clk);
    pm_wr_req <= 1'b0;
    @(posedge clk);
    chk("write gate", {30'h0, ok, !ok}, {30'h0, pm_wr_ok, pm_wr_rej});
  endtask : pmw
  task automatic ovr(input logic [15:0] b, input logic [15:0] a, input int ms);
    int n0;
    int d;
    wr(IDX_CTRL, 32'h8);
    wr(IDX_MON, {16'h0, a});
    n0 = n_err;
    wr(IDX_CTRL, 32'hC);
    wr(IDX_MON, {16'h0, b});
    while (n_err == n0) @(posedge clk);
    d = err_cyc - last_start;
    chk("overrun time", 32'h1, {31'h0, d > ms * TK && d <= ms * TK + TK + 4});
  endtask : ovr
  // ***************************
  // tests
  // ***************************
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(2);
    chk("boot mode", 32'h0, {30'h0, op_mode});
    rd(IDX_STS, 32'h8);
    foreach (cfg[k]) begin
      rd(cfg[k], 32'h0);
      wr(cfg[k], 32'hFFFF_A5C3);
      rd(cfg[k], 32'h0000_A5C3);
      wr(cfg[k], 32'h0);
    end
    apb(1'b0, 16'h0004, 32'h0);
    chk("unmapped", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rv);
    apb(1'b1, {IDX_MODE, 2'b10}, 32'h2);
    chk("misaligned", 32'h1, {31'h0, re});
    pm = 2'h0;
    foreach (mt[k]) begin
      mode_switch <= mt[k][17:16];
      wr(IDX_MODE, {16'h0, mt[k][15:0]});
      chk("mode before restart", {30'h0, pm}, {30'h0, op_mode});
      boot();
      chk("start mode", {30'h0, mt[k][19:18]}, {30'h0, op_mode});
      pm = mt[k][19:18];
    end
    foreach (ht[k]) begin
      wr(IDX_CTRL, 32'h70);
      wr(IDX_HOLD, {16'h0, ht[k][15:0]});
      chk("hold before restart", 32'h3, {30'h0, force_hold, io_hold});
      boot();
      chk("hold flags", {30'h0, ht[k][17:16]}, {30'h0, force_hold, io_hold});
    end
    wr(IDX_STS, 32'hF);
    wr(IDX_PROT, 32'h11);
    pmw(1'b1);
    boot();
    chk("language", 32'h1, {31'h0, lang_jp});
    pmw(1'b0);
    rd(IDX_STS, 32'hC);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_MASK, 32'h4);
    tick(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IDX_STS, 32'h4);
    tick(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_PROT, 32'h0);
    boot();
    chk("language", 32'h0, {31'h0, lang_jp});
    pmw(1'b1);
    wr(IDX_MASK, 32'h0);
    exec_on = 1'b1;
    foreach (st[k]) begin
      wr(IDX_CTRL, 32'h8);
      wr(IDX_PERI, {16'h0, st[k][15:0]});
      wr(IDX_MIN, {16'h0, st[k][31:16]});
      wr(IDX_CTRL, 32'hC);
      tick(700);
      lo = gl[k] - gl[k] / 16 - 2;
      hi = gl[k] + gl[k] / 16 + 2;
      chk("service length", 32'h1, {31'h0, glast >= lo && glast <= hi});
      nb = last_start - prev_start;
      hi = (mp[k] == 0) ? gl[k] + 50 : mp[k] + 6;
      chk("scan period", 32'h1, {31'h0, nb >= mp[k] && nb <= hi});
    end
    exec_on = 1'b0;
    wr(IDX_MIN, 32'h0);
    foreach (ot[k]) ovr(ot[k][31:16], ot[k][15:0], om[k]);
    wr(IDX_ELOG, 32'h100);
    wr(IDX_CTRL, 32'h8);
    wr(IDX_MON, 32'h101);
    wr(IDX_STS, 32'hF);
    nb = n_err;
    wr(IDX_CTRL, 32'hC);
    tick(15 * TK);
    chk("silent long cycle", nb, n_err);
    rd(IDX_STS, 32'h1);
    results();
  end
endmodule : scs_setup_bench

// ---- scs_setup_sva.sv ----
// assertion checker for the startup and cycle time setup block
module scs_setup_sva (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic restart_req, // restart pulse
  input wire logic exec_done, // pass finished
  input wire logic pm_wr_req, // write attempt
  input wire logic pm_wr_ok, // write accepted
  input wire logic pm_wr_rej, // write rejected
  input wire logic [1:0] op_mode, // operating mode
  input wire logic scan_start, // scan start
  input wire logic periph_grant, // service window
  input wire logic cycle_err // long cycle error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ***************************
  // apb answer
  // ***************************
  chk_ready_time: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access start");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_wr_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  // ***************************
  // startup and scan
  // ***************************
  chk_wr_gate: assert property (pm_wr_req |=> pm_wr_ok != pm_wr_rej)
    else $error("write gate gave no single answer");
  chk_gate_cause: assert property (pm_wr_ok || pm_wr_rej |-> $past(pm_wr_req))
    else $error("write gate answer without request");
  chk_mode_hold: assert property ($changed(op_mode) |->
    $past(restart_req) || $past(pready) || $past(pready, 2))
    else $error("mode changed without restart or write");
  chk_grant_cause: assert property ($rose(periph_grant) |-> $past(exec_done))
    else $error("service window not after pass end");
  chk_start_pulse: assert property (scan_start |=> !scan_start)
    else $error("scan start longer than one cycle");
  chk_start_nogrant: assert property (scan_start |-> !periph_grant)
    else $error("service window at scan start");
  chk_err_pulse: assert property (cycle_err |=> !cycle_err)
    else $error("long cycle error longer than one cycle");
endmodule : scs_setup_sva

bind scs_setup scs_setup_sva chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .restart_req(restart_req), .exec_done(exec_done), .pm_wr_req(pm_wr_req),
  .pm_wr_ok(pm_wr_ok), .pm_wr_rej(pm_wr_rej), .op_mode(op_mode), .scan_start(scan_start),
  .periph_grant(periph_grant), .cycle_err(cycle_err));
